// file: ftsr_pkg.sv
package ftsr_pkg;
    localparam logic [7:0] FTSR_ADDR_TIMER = 8'h03;
    localparam logic [7:0] FTSR_ADDR_PTI   = 8'h04;
    localparam int FTSR_TDUR_MSB = 7;
    localparam int FTSR_TDUR_LSB = 5;
    localparam int FTSR_FAIL_BIT = 4;
    localparam int FTSR_RANGE_BIT = 3;
    localparam int FTSR_TRIG_BIT = 2;
    localparam int FTSR_START_BIT = 1;
    localparam int FTSR_BLANK_BIT = 0;
    localparam int FTSR_PG_BIT = 7;
    localparam int FTSR_TEMP_MSB = 6;
    localparam int FTSR_TEMP_LSB = 5;
    localparam int FTSR_CURRENT_LIMIT_BIT_BIT = 4;
    localparam int FTSR_IND_MSB = 3;
    localparam logic [7:0] FTSR_TIMER_RST = 8'hC1;
    localparam logic [7:0] FTSR_PTI_RST   = 8'h00;
    localparam int FTSR_CLK_KHZ = 250000;
    localparam int FTSR_TICK_US = 100;
    localparam int FTSR_TICK_CYC = FTSR_CLK_KHZ * FTSR_TICK_US / 1000;
    localparam int FTSR_CNT_W = 14;
    typedef enum logic [1:0] {
        FTSR_MODE_SHUTDOWN = 2'b00,
        FTSR_MODE_VIDEO    = 2'b01,
        FTSR_MODE_FLASH    = 2'b10,
        FTSR_MODE_VSOURCE  = 2'b11
    } ftsr_mode_t;
    typedef enum logic [1:0] {
        FTSR_ST_IDLE   = 2'b00,
        FTSR_ST_STROBE = 2'b01,
        FTSR_ST_ARMED  = 2'b10
    } ftsr_state_t;
    // Durations in 0.1 ms ticks; range 0 first, then range 1.
    localparam logic [13:0] FTSR_DUR0 [8] = '{14'h02AA, 14'h03FE, 14'h0553, 14'h06A8,
                                             14'h07FD, 14'h0D50, 14'h16A1, 14'h2148};
    localparam logic [13:0] FTSR_DUR1 [8] = '{14'h0035, 14'h006B, 14'h00A0, 14'h00D5,
                                             14'h010A, 14'h0140, 14'h0175, 14'h02CB};
endpackage

// file: ftsr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ftsr_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             reset,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    always_ff @(posedge mclk) begin
        if (reset) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end
    assign syncOut = stage2_ff;
endmodule
`default_nettype wire

// file: ftsr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ftsr_regs
    import ftsr_pkg::*;
#(
    parameter int TICK_CYC = ftsr_pkg::FTSR_TICK_CYC
) (
    // Clock and reset.
    input  wire logic                   mclk,
    input  wire logic                   reset,
    // Register port from the serial interface logic.
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    input  wire logic                   readDone,
    input  wire logic [7:0]             regAddr,
    input  wire logic [7:0]             regWdata,
    output logic      [7:0]             regRdata,
    // Device state.
    input  wire ftsr_pkg::ftsr_mode_t   modeCtrl,
    input  wire logic                   primaryStrobeInput,
    input  wire logic                   txMaskInput,
    input  wire logic                   ledFault,
    input  wire logic                   powerGoodIn,
    input  wire logic [1:0]             dieTemperatureIn,
    // Controls to the LED drivers.
    output logic                        flashActive,
    output logic                        blankingActive,
    output logic                        powerGoodSel,
    output logic                        currentLimitSel,
    output logic [3:0]                  indicatorControl
);
    import ftsr_pkg::*;
    logic [3:0]  syncd;
    logic        strobeS, maskS, faultS, pgS;
    logic [1:0]  tempS;
    logic [2:0]  durSel_ff;
    logic        rangeSel_ff, trigStyle_ff, blankEn_ff;
    logic        failFlag_ff, timeoutFlag_ff, maskFlag_ff;
    logic        failSeen_ff, maskSeen_ff;
    logic        strobePrev_ff;
    logic [7:0]  pti_ff;
    logic [7:0]  rdata_ff;
    logic [15:0] tickCnt_ff;
    logic [13:0] elapsed_ff;
    logic [13:0] limit;
    logic        tick, startReq, expired, wrTimer, rdTimer;
    ftsr_state_t state_ff;

    ftsr_sync #(.WIDTH(4)) u_sync (
        .mclk    (mclk),
        .reset   (reset),
        .asyncIn ({primaryStrobeInput, txMaskInput, ledFault, powerGoodIn}),
        .syncOut (syncd)
    );
    assign {strobeS, maskS, faultS, pgS} = syncd;
    // Temperature is a slow two-bit code; a torn sample only lasts a cycle.
    ftsr_sync #(.WIDTH(2)) u_sync_t (
        .mclk    (mclk),
        .reset   (reset),
        .asyncIn (dieTemperatureIn),
        .syncOut (tempS)
    );

    assign wrTimer = regWrite && (regAddr == FTSR_ADDR_TIMER);
    assign rdTimer = regRead && (regAddr == FTSR_ADDR_TIMER);

    always_ff @(posedge mclk) begin
        if (reset) begin
            durSel_ff    <= FTSR_TIMER_RST[FTSR_TDUR_MSB:FTSR_TDUR_LSB];
            rangeSel_ff  <= 1'b0;
            trigStyle_ff <= FTSR_TIMER_RST[FTSR_TRIG_BIT];
            blankEn_ff   <= FTSR_TIMER_RST[FTSR_BLANK_BIT];
        end else if (wrTimer) begin
            durSel_ff    <= regWdata[FTSR_TDUR_MSB:FTSR_TDUR_LSB];
            rangeSel_ff  <= regWdata[FTSR_RANGE_BIT];
            trigStyle_ff <= regWdata[FTSR_TRIG_BIT];
            blankEn_ff   <= regWdata[FTSR_BLANK_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pti_ff <= FTSR_PTI_RST;
        end else if (regWrite && regAddr == FTSR_ADDR_PTI) begin
            pti_ff <= regWdata;
        end
    end
    assign powerGoodSel     = pti_ff[FTSR_PG_BIT];
    assign currentLimitSel  = pti_ff[FTSR_CURRENT_LIMIT_BIT_BIT];
    assign indicatorControl = pti_ff[FTSR_IND_MSB:0];

    // A tick every 0.1 ms keeps the duration tables exact to the printed digit.
    always_ff @(posedge mclk) begin
        if (reset || state_ff != FTSR_ST_STROBE) begin
            tickCnt_ff <= '0;
        end else if (tick) begin
            tickCnt_ff <= '0;
        end else begin
            tickCnt_ff <= tickCnt_ff + 16'h0001;
        end
    end
    assign tick = (tickCnt_ff == 16'(TICK_CYC - 1));
    assign limit = rangeSel_ff ? FTSR_DUR1[durSel_ff] : FTSR_DUR0[durSel_ff];
    assign expired = tick && (elapsed_ff + 14'h0001 >= limit);

    // Edge style applies only in flash mode; elsewhere the level starts it.
    assign startReq = (trigStyle_ff && modeCtrl == FTSR_MODE_FLASH)
                      ? (strobeS && !strobePrev_ff) : strobeS;

    always_ff @(posedge mclk) begin
        if (reset) begin
            strobePrev_ff <= 1'b0;
        end else begin
            strobePrev_ff <= strobeS;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff   <= FTSR_ST_IDLE;
            elapsed_ff <= '0;
        end else begin
            case (state_ff)
                FTSR_ST_IDLE: begin
                    if (wrTimer && regWdata[FTSR_START_BIT]) begin
                        state_ff <= FTSR_ST_ARMED;
                    end
                end
                FTSR_ST_ARMED: begin
                    if (wrTimer && !regWdata[FTSR_START_BIT]) begin
                        state_ff <= FTSR_ST_ARMED;
                    end else if (strobeS && startReq) begin
                        state_ff   <= FTSR_ST_STROBE;
                        elapsed_ff <= '0;
                    end
                end
                FTSR_ST_STROBE: begin
                    if (expired) begin
                        state_ff <= FTSR_ST_IDLE;
                    end else if (!strobeS && !(trigStyle_ff && modeCtrl == FTSR_MODE_FLASH)) begin
                        state_ff <= FTSR_ST_IDLE;
                    end else if (tick) begin
                        elapsed_ff <= elapsed_ff + 14'h0001;
                    end
                end
                default: state_ff <= FTSR_ST_IDLE;
            endcase
        end
    end
    assign flashActive = (state_ff == FTSR_ST_STROBE);
    // Blanking follows the mask input while the blank enable bit is set, so a strobe that starts under mask never peaks.
    assign blankingActive = blankEn_ff && maskS;

    always_ff @(posedge mclk) begin
        if (reset) begin
            timeoutFlag_ff <= 1'b0;
        end else if (flashActive && expired) begin
            timeoutFlag_ff <= 1'b1;
        end else if (state_ff == FTSR_ST_ARMED && strobeS && startReq) begin
            timeoutFlag_ff <= 1'b0;
        end
    end

    // Set wins over the clear; the clear waits for the host to finish the read.
    always_ff @(posedge mclk) begin
        if (reset) begin
            failFlag_ff <= 1'b0;
            failSeen_ff <= 1'b0;
            maskFlag_ff <= 1'b0;
            maskSeen_ff <= 1'b0;
        end else begin
            failSeen_ff <= rdTimer ? failFlag_ff : (readDone ? 1'b0 : failSeen_ff);
            maskSeen_ff <= rdTimer ? maskFlag_ff : (readDone ? 1'b0 : maskSeen_ff);
            if (faultS) begin
                failFlag_ff <= 1'b1;
            end else if (readDone && failSeen_ff) begin
                failFlag_ff <= 1'b0;
            end
            if (blankEn_ff && maskS) begin
                maskFlag_ff <= 1'b1;
            end else if (readDone && maskSeen_ff) begin
                maskFlag_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                FTSR_ADDR_TIMER: rdata_ff <= {durSel_ff, failFlag_ff, timeoutFlag_ff,
                                              trigStyle_ff, flashActive, maskFlag_ff};
                FTSR_ADDR_PTI:   rdata_ff <= {pgS, tempS, pti_ff[FTSR_CURRENT_LIMIT_BIT_BIT], pti_ff[FTSR_IND_MSB:0]};
                default:         rdata_ff <= 8'h00;
            endcase
        end
    end
    assign regRdata = rdata_ff;

    sequence s_expiry;
        flashActive && expired;
    endsequence
    sequence s_strobe_begin;
        $rose(flashActive);
    endsequence

    a_timeout_sets: assert property (@(posedge mclk) disable iff (reset)
        s_expiry |=> timeoutFlag_ff && !flashActive)
        else $error("timeout flag or strobe end missing");
    a_fail_sticky: assert property (@(posedge mclk) disable iff (reset)
        faultS |=> failFlag_ff)
        else $error("failure flag not set");
    a_fail_clear: assert property (@(posedge mclk) disable iff (reset)
        $fell(failFlag_ff) |-> $past(readDone) && $past(failSeen_ff))
        else $error("failure flag cleared without read");
    a_mask_clear: assert property (@(posedge mclk) disable iff (reset)
        $fell(maskFlag_ff) |-> $past(readDone))
        else $error("mask flag cleared without read");
    a_strobe_gate: assert property (@(posedge mclk) disable iff (reset)
        s_strobe_begin |-> $past(strobeS))
        else $error("strobe started without strobe input");
    a_blank_level: assert property (@(posedge mclk) disable iff (reset)
        blankingActive |=> maskFlag_ff)
        else $error("blanking event not flagged");
    a_timeout_hold: assert property (@(posedge mclk) disable iff (reset)
        timeoutFlag_ff && !$rose(flashActive) |=> timeoutFlag_ff || flashActive)
        else $error("timeout flag lost");
    a_edge_mode: assert property (@(posedge mclk) disable iff (reset)
        $rose(flashActive) && trigStyle_ff && modeCtrl == FTSR_MODE_FLASH
        |-> $past(strobeS && !strobePrev_ff))
        else $error("edge trigger started on level");
endmodule
`default_nettype wire

// file: ftsr_camera_model.sv
`timescale 1ns/1ps
`default_nettype none
module ftsr_camera_model (
    // Clock.
    input  wire logic mclk,
    // Lines into the device.
    output logic      primaryStrobeInput,
    output logic      txMaskInput,
    output logic      ledFault
);
    initial begin
        primaryStrobeInput = 1'b0;
        txMaskInput = 1'b0;
        ledFault = 1'b0;
    end
    // Levels stay put until the camera changes them, so a started flash keeps its strobe high.
    task automatic drive(input logic strobe, input logic mask, input logic fault);
        @(posedge mclk);
        primaryStrobeInput <= strobe;
        txMaskInput <= mask;
        ledFault <= fault;
    endtask
endmodule
`default_nettype wire

// file: ftsr_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ftsr_regs_bench;
    import ftsr_pkg::*;
    logic                mclk = 1'b0;
    logic                reset = 1'b1;
    logic                regWrite = 1'b0;
    logic                regRead = 1'b0;
    logic                readDone = 1'b0;
    logic [7:0]          regAddr = 8'h00;
    logic [7:0]          regWdata = 8'h00;
    logic [7:0]          regRdata;
    ftsr_mode_t          modeCtrl = FTSR_MODE_SHUTDOWN;
    logic                powerGoodIn = 1'b0;
    logic [1:0]          dieTemperatureIn = 2'h0;
    logic                strobe;
    logic                mask;
    logic                fault;
    logic                flashActive;
    logic                blankingActive;
    logic                powerGoodSel;
    logic                currentLimitSel;
    logic [3:0]          indicatorControl;
    int                  failures = 0;
    int                  samples_checked = 0;
    logic [7:0]          d;
    int                  n;

    always #2 mclk = ~mclk;

    ftsr_camera_model ftsr_camera_model_inst (.mclk(mclk), .primaryStrobeInput(strobe), .txMaskInput(mask),
        .ledFault(fault));
    // A short tick keeps the safety timer inside a brief run.
    ftsr_regs #(.TICK_CYC(2)) ftsr_regs_inst (.mclk(mclk), .reset(reset), .regWrite(regWrite),
        .regRead(regRead), .readDone(readDone), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .modeCtrl(modeCtrl), .primaryStrobeInput(strobe), .txMaskInput(mask), .ledFault(fault),
        .powerGoodIn(powerGoodIn), .dieTemperatureIn(dieTemperatureIn), .flashActive(flashActive),
        .blankingActive(blankingActive), .powerGoodSel(powerGoodSel), .currentLimitSel(currentLimitSel),
        .indicatorControl(indicatorControl));

    task automatic final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task automatic rdReg(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 v = regRdata;
    endtask
    task automatic endRead();
        @(posedge mclk);
        readDone <= 1'b1;
        @(posedge mclk);
        readDone <= 1'b0;
    endtask
    // Bounded wait, so a stuck strobe shows up as a wrong count instead of a hang.
    task automatic waitFlash(input logic lvl, output int cnt);
        cnt = 0;
        while (flashActive !== lvl && cnt < 5000) begin
            @(posedge mclk);
            #1 cnt++;
        end
    endtask

    task automatic test_reset();
        rdReg(FTSR_ADDR_TIMER, d);
        check("timerReset", d & 8'hFE, FTSR_TIMER_RST & 8'hFE);
        rdReg(FTSR_ADDR_PTI, d);
        check("ptiReset", d, FTSR_PTI_RST);
        check("ptiOutReset", {2'h0, powerGoodSel, currentLimitSel, indicatorControl}, 8'h00);
    endtask
    task automatic test_pti_unmapped();
        @(posedge mclk);
        powerGoodIn <= 1'b1;
        dieTemperatureIn <= 2'h2;
        wrReg(FTSR_ADDR_PTI, 8'hFF);
        wrReg(8'h07, 8'hFF);
        repeat (4) @(posedge mclk);
        rdReg(FTSR_ADDR_PTI, d);
        check("ptiRead", d, 8'hDF);
        check("ptiOut", {2'h0, powerGoodSel, currentLimitSel, indicatorControl}, 8'h3F);
        rdReg(8'h07, d);
        check("unmappedRead", d, 8'h00);
    endtask
    task automatic test_level_timeout();
        @(posedge mclk);
        modeCtrl <= FTSR_MODE_FLASH;
        wrReg(FTSR_ADDR_TIMER, 8'h0A);
        ftsr_camera_model_inst.drive(1'b1, 1'b0, 1'b0);
        waitFlash(1'b1, n);
        check("levelStart", {7'h0, flashActive}, 8'h01);
        waitFlash(1'b0, n);
        check("strobeLen", {7'h0, n >= 100 && n <= 112}, 8'h01);
        rdReg(FTSR_ADDR_TIMER, d);
        check("timeoutRead", d, 8'h08);
    endtask
    // Code 100 in range 0 is 204.5 ms, that is 2045 ticks of two cycles each.
    task automatic test_range0();
        wrReg(FTSR_ADDR_TIMER, 8'h82);
        waitFlash(1'b1, n);
        waitFlash(1'b0, n);
        check("range0Len", {7'h0, n >= 4089 && n <= 4091}, 8'h01);
        rdReg(FTSR_ADDR_TIMER, d);
        check("range0Timeout", d, 8'h88);
    endtask
    task automatic test_trig_ignored();
        @(posedge mclk);
        modeCtrl <= FTSR_MODE_VIDEO;
        ftsr_camera_model_inst.drive(1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge mclk);
        wrReg(FTSR_ADDR_TIMER, 8'h0E);
        waitFlash(1'b1, n);
        check("trigIgnored", {7'h0, flashActive}, 8'h01);
        ftsr_camera_model_inst.drive(1'b0, 1'b0, 1'b0);
        waitFlash(1'b0, n);
        check("levelEnd", {7'h0, n <= 8}, 8'h01);
    endtask
    task automatic test_edge_restart();
        wrReg(FTSR_ADDR_TIMER, 8'h0E);
        repeat (10) @(posedge mclk);
        check("edgeNoStart", {7'h0, flashActive}, 8'h00);
        ftsr_camera_model_inst.drive(1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge mclk);
        ftsr_camera_model_inst.drive(1'b1, 1'b0, 1'b0);
        waitFlash(1'b1, n);
        rdReg(FTSR_ADDR_TIMER, d);
        check("edgeRunRead", d, 8'h06);
        waitFlash(1'b0, n);
        ftsr_camera_model_inst.drive(1'b0, 1'b0, 1'b0);
    endtask
    task automatic test_fault_flag();
        ftsr_camera_model_inst.drive(1'b0, 1'b0, 1'b1);
        ftsr_camera_model_inst.drive(1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge mclk);
        rdReg(FTSR_ADDR_TIMER, d);
        check("failSet", {7'h0, d[FTSR_FAIL_BIT]}, 8'h01);
        rdReg(FTSR_ADDR_TIMER, d);
        check("failKept", {7'h0, d[FTSR_FAIL_BIT]}, 8'h01);
        endRead();
        rdReg(FTSR_ADDR_TIMER, d);
        check("failCleared", {7'h0, d[FTSR_FAIL_BIT]}, 8'h00);
    endtask
    task automatic test_mask();
        wrReg(FTSR_ADDR_TIMER, 8'h01);
        ftsr_camera_model_inst.drive(1'b0, 1'b1, 1'b0);
        repeat (4) @(posedge mclk);
        check("blankOn", {7'h0, blankingActive}, 8'h01);
        ftsr_camera_model_inst.drive(1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge mclk);
        rdReg(FTSR_ADDR_TIMER, d);
        check("maskFlag", {7'h0, d[FTSR_BLANK_BIT]}, 8'h01);
        endRead();
        rdReg(FTSR_ADDR_TIMER, d);
        check("maskCleared", {7'h0, d[FTSR_BLANK_BIT]}, 8'h00);
        wrReg(FTSR_ADDR_TIMER, 8'h00);
        ftsr_camera_model_inst.drive(1'b0, 1'b1, 1'b0);
        repeat (4) @(posedge mclk);
        check("blankOff", {7'h0, blankingActive}, 8'h00);
        ftsr_camera_model_inst.drive(1'b0, 1'b0, 1'b0);
    endtask

    // Whole sequence needs a few thousand cycles; the margin is generous.
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        test_reset();
        test_pti_unmapped();
        test_level_timeout();
        test_range0();
        test_edge_restart();
        test_trig_ignored();
        test_fault_flag();
        test_mask();
        final_report();
    end
endmodule
`default_nettype wire
